/* File: design/clk_ctrl_pkg.sv */
// Constants, field layouts and carrier types for the clock select and prescaler block
//
// Overview of operation
// - Slow select bit 0 picks slow source
// - Fast select: 0 PLL, 1 Main; reset 1
// - Ignore switching to PLL while shut down
// - Switch to PLL only once PLL stable
// - Shutdown bit stops PLL; set after reset
// - Ignore shutdown set while PLL selected
// - Aux 1 runs if enabled and Main stable
// - Aux 2 runs if enabled and Main stable
// - Power-on flag set by hardware, write-zero clears
// - System clock divides by fast divisor plus one
// - Multiplier codes 011, 100, 101 only valid
// - Multiplier resets to 100 for 48 MHz
// - Slow divides Main by 2 times (divisor+1)
// - Aux divides by own divisor plus one
`default_nettype none
package clk_ctrl_pkg;

	// ****************************************
	// Register indices (byte address = index * 4)
	// ****************************************
	localparam int ADDR_W = 10;
	localparam logic [7:0] IDX_CLOCK_RESET_CONTROL = 8'h40;
	localparam logic [7:0] IDX_FAST_CLOCK_PRESCALE = 8'h42;
	localparam logic [7:0] IDX_SLOW_CLOCK_PRESCALE = 8'h44;
	localparam logic [7:0] IDX_AUX_CLOCK_PRESCALE = 8'h46;

	// ****************************************
	// Control register bit positions
	// ****************************************
	localparam int BIT_SLOW_SELECT = 0;
	localparam int BIT_FAST_SELECT = 1;
	localparam int BIT_PLL_SHUTDOWN = 2;
	localparam int BIT_AUX1_ENABLE = 3;
	localparam int BIT_AUX2_ENABLE = 4;
	localparam int BIT_POWER_ON = 5;

	// ****************************************
	// Prescale field positions
	// ****************************************
	localparam int FAST_DIV_LSB = 0;
	localparam int FAST_DIV_MSB = 3;
	localparam int PLL_MODE_LSB = 4;
	localparam int PLL_MODE_MSB = 6;
	localparam int AUX1_DIV_LSB = 0;
	localparam int AUX1_DIV_MSB = 3;
	localparam int AUX2_DIV_LSB = 4;
	localparam int AUX2_DIV_MSB = 7;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic RST_SLOW_SELECT = 1'b0;
	localparam logic RST_FAST_SELECT = 1'b1;
	localparam logic RST_PLL_SHUTDOWN = 1'b1;
	localparam logic RST_AUX_ENABLE = 1'b0;
	localparam logic RST_POWER_ON = 1'b1;
	localparam logic [3:0] RST_FAST_DIV = 4'h0;
	localparam logic [7:0] RST_SLOW_DIV = 8'hB6;
	localparam logic [7:0] RST_AUX_PRESCALE = 8'hFF;

	// PLL multiplier codes
	typedef enum logic [2:0] {
		PLL_X3 = 3'b011,
		PLL_X4 = 3'b100,
		PLL_X5 = 3'b101
	} pll_mode_t;
	localparam pll_mode_t RST_PLL_MODE = PLL_X4;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic main_tick;
		logic pll_tick;
		logic lfo_tick;
		logic main_stable;
		logic pll_stable;
	} clk_src_t;

	typedef struct packed {
		logic sys_tick;
		logic slow_tick;
		logic aux1_tick;
		logic aux2_tick;
	} clk_out_t;

endpackage
`default_nettype wire

/* File: design/tick_divider.sv */
// Enable-pulse divider: one output pulse for every (divisor + 1) input ticks
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic run,
	input wire logic [W-1:0] divisor,
	output logic pulse
);

	logic [W-1:0] count;

	// Count source ticks; >= keeps a lowered divisor from stretching a period
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			pulse <= 1'b0;
		end else if (!run) begin
			count <= '0;
			pulse <= 1'b0;
		end else if (tick) begin
			if (count >= divisor) begin
				count <= '0;
				pulse <= 1'b1;
			end else begin
				count <= count + W'(1);
				pulse <= 1'b0;
			end
		end else begin
			pulse <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: design/clock_select_prescaler_ctrl.sv */
// Clock source selection, PLL control and prescalers behind an APB slave
`timescale 1ns/100ps
`default_nettype none
module clock_select_prescaler_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [clk_ctrl_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire clk_ctrl_pkg::clk_src_t src,
	input wire logic power_on_detect,
	output clk_ctrl_pkg::clk_out_t clk_out,
	output logic pll_shutdown,
	output clk_ctrl_pkg::pll_mode_t pll_mode
);
	import clk_ctrl_pkg::*;

	// ****************************************
	// Register state
	// ****************************************
	logic slow_select;
	logic fast_select;
	logic aux1_enable;
	logic aux2_enable;
	logic por_flag;
	logic [3:0] fast_divisor;
	logic [7:0] slow_divisor;
	logic [3:0] aux1_divisor;
	logic [3:0] aux2_divisor;
	logic ack;
	logic next_fast_select;
	logic next_pll_shutdown;

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] index);
		byte_addr = {index, 2'b00};
	endfunction

	// Address match against one register
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] index);
		hit = (a == byte_addr(index));
	endfunction

	// Only the three documented multiplier codes are accepted
	function automatic logic mode_legal(input logic [2:0] m);
		mode_legal = (m == PLL_X3) || (m == PLL_X4) || (m == PLL_X5);
	endfunction

	// ****************************************
	// APB slave
	// ****************************************
	logic sel_ctrl;
	logic sel_fast;
	logic sel_slow;
	logic sel_aux;
	logic mapped;
	logic wr_commit;
	logic wr_low;

	assign sel_ctrl = hit(paddr, IDX_CLOCK_RESET_CONTROL);
	assign sel_fast = hit(paddr, IDX_FAST_CLOCK_PRESCALE);
	assign sel_slow = hit(paddr, IDX_SLOW_CLOCK_PRESCALE);
	assign sel_aux = hit(paddr, IDX_AUX_CLOCK_PRESCALE);
	assign mapped = sel_ctrl | sel_fast | sel_slow | sel_aux;
	// Write lands on the edge where pready is seen high; only the low lane is live
	assign wr_commit = psel & penable & ack & pwrite & mapped;
	assign wr_low = wr_commit & pstrb[0];

	// One wait state so read data can come from a flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
		end else begin
			ack <= psel & penable & ~ack;
		end
	end

	assign pready = ack;
	assign pslverr = ack & ~mapped;

	// Read data captured in the first access cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel & penable & ~ack) begin
			prdata <= 32'h0000_0000;
			if (sel_ctrl) begin
				prdata[BIT_SLOW_SELECT] <= slow_select;
				prdata[BIT_FAST_SELECT] <= fast_select;
				prdata[BIT_PLL_SHUTDOWN] <= pll_shutdown;
				prdata[BIT_AUX1_ENABLE] <= aux1_enable;
				prdata[BIT_AUX2_ENABLE] <= aux2_enable;
				prdata[BIT_POWER_ON] <= por_flag;
			end else if (sel_fast) begin
				prdata[FAST_DIV_MSB:FAST_DIV_LSB] <= fast_divisor;
				prdata[PLL_MODE_MSB:PLL_MODE_LSB] <= pll_mode;
			end else if (sel_slow) begin
				prdata[7:0] <= slow_divisor;
			end else if (sel_aux) begin
				prdata[AUX1_DIV_MSB:AUX1_DIV_LSB] <= aux1_divisor;
				prdata[AUX2_DIV_MSB:AUX2_DIV_LSB] <= aux2_divisor;
			end
		end
	end

	// ****************************************
	// Fast select and PLL shutdown interlock
	// ****************************************
	// Both bits judged together so one write cannot leave the PLL off while selected
	always_comb begin
		next_fast_select = fast_select;
		next_pll_shutdown = pll_shutdown;
		if (wr_low && sel_ctrl) begin
			if (pwdata[BIT_FAST_SELECT]) begin
				next_fast_select = 1'b1;
			end else if (src.pll_stable && !pll_shutdown && !pwdata[BIT_PLL_SHUTDOWN]) begin
				next_fast_select = 1'b0;
			end
			if (!pwdata[BIT_PLL_SHUTDOWN]) begin
				next_pll_shutdown = 1'b0;
			end else if (next_fast_select) begin
				next_pll_shutdown = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_select <= RST_FAST_SELECT;
			pll_shutdown <= RST_PLL_SHUTDOWN;
		end else begin
			fast_select <= next_fast_select;
			pll_shutdown <= next_pll_shutdown;
		end
	end

	// Plain control bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_select <= RST_SLOW_SELECT;
			aux1_enable <= RST_AUX_ENABLE;
			aux2_enable <= RST_AUX_ENABLE;
		end else if (wr_low && sel_ctrl) begin
			slow_select <= pwdata[BIT_SLOW_SELECT];
			aux1_enable <= pwdata[BIT_AUX1_ENABLE];
			aux2_enable <= pwdata[BIT_AUX2_ENABLE];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			por_flag <= RST_POWER_ON;
		end else if (power_on_detect) begin
			por_flag <= 1'b1;
		end else if (wr_low && sel_ctrl && !pwdata[BIT_POWER_ON]) begin
			por_flag <= 1'b0;
		end
	end

	// ****************************************
	// Prescale registers
	// ****************************************
	// multiplier code kept legal
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pll_mode <= RST_PLL_MODE;
			fast_divisor <= RST_FAST_DIV;
		end else if (wr_low && sel_fast) begin
			fast_divisor <= pwdata[FAST_DIV_MSB:FAST_DIV_LSB];
			if (mode_legal(pwdata[PLL_MODE_MSB:PLL_MODE_LSB])) begin
				pll_mode <= pll_mode_t'(pwdata[PLL_MODE_MSB:PLL_MODE_LSB]);
			end
		end
	end

	// Slow and auxiliary divisors
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_divisor <= RST_SLOW_DIV;
			aux1_divisor <= RST_AUX_PRESCALE[AUX1_DIV_MSB:AUX1_DIV_LSB];
			aux2_divisor <= RST_AUX_PRESCALE[AUX2_DIV_MSB:AUX2_DIV_LSB];
		end else if (wr_low) begin
			if (sel_slow) begin
				slow_divisor <= pwdata[7:0];
			end
			if (sel_aux) begin
				aux1_divisor <= pwdata[AUX1_DIV_MSB:AUX1_DIV_LSB];
				aux2_divisor <= pwdata[AUX2_DIV_MSB:AUX2_DIV_LSB];
			end
		end
	end

	// ****************************************
	// Clock generation
	// ****************************************
	logic fast_src_tick;
	logic main_slow_tick;
	logic aux1_run;
	logic aux2_run;
	logic sys_pulse;
	logic slow_pulse;
	logic aux1_pulse;
	logic aux2_pulse;

	// One driver for the whole carrier; each member comes from its own flop
	assign clk_out = {sys_pulse, slow_pulse, aux1_pulse, aux2_pulse};

	assign fast_src_tick = fast_select ? src.main_tick : src.pll_tick;
	assign aux1_run = aux1_enable & src.main_stable;
	assign aux2_run = aux2_enable & src.main_stable;

	// system divide by divisor plus one
	tick_divider #(.W(4)) u_sys_div (
		.clk(clk),
		.rst_n(rst_n),
		.tick(fast_src_tick),
		.run(1'b1),
		.divisor(fast_divisor),
		.pulse(sys_pulse)
	);

	tick_divider #(.W(9)) u_slow_div (
		.clk(clk),
		.rst_n(rst_n),
		.tick(src.main_tick),
		.run(~slow_select),
		.divisor({slow_divisor, 1'b1}),
		.pulse(main_slow_tick)
	);

	tick_divider #(.W(4)) u_aux1_div (
		.clk(clk),
		.rst_n(rst_n),
		.tick(src.main_tick),
		.run(aux1_run),
		.divisor(aux1_divisor),
		.pulse(aux1_pulse)
	);

	tick_divider #(.W(4)) u_aux2_div (
		.clk(clk),
		.rst_n(rst_n),
		.tick(src.main_tick),
		.run(aux2_run),
		.divisor(aux2_divisor),
		.pulse(aux2_pulse)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_pulse <= 1'b0;
		end else begin
			slow_pulse <= slow_select ? src.lfo_tick : main_slow_tick;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_PLL_SELECTED_NOT_OFF: assert property (!fast_select |-> !pll_shutdown)
		else $error("PLL selected while shut down");

	AST_PLL_SWITCH_STABLE: assert property ($fell(fast_select) |-> $past(src.pll_stable))
		else $error("switched to PLL before it was stable");

	AST_SHUTDOWN_SET_IGNORED: assert property (
		wr_low && sel_ctrl && pwdata[BIT_PLL_SHUTDOWN] && !pwdata[BIT_FAST_SELECT] && !fast_select
		|=> pll_shutdown == $past(pll_shutdown))
		else $error("shutdown set while PLL selected");

	AST_AUX1_STOPPED: assert property (!aux1_run |=> !clk_out.aux1_tick)
		else $error("aux clock 1 ticked while stopped");

	AST_AUX2_STOPPED: assert property (!aux2_run |=> !clk_out.aux2_tick)
		else $error("aux clock 2 ticked while stopped");

	AST_POWER_ON_SET: assert property (power_on_detect |=> por_flag)
		else $error("power-on flag not set");

	AST_POWER_ON_WRITE_ONE: assert property (
		wr_low && sel_ctrl && pwdata[BIT_POWER_ON] && !power_on_detect
		|=> por_flag == $past(por_flag))
		else $error("writing one changed power-on flag");

	AST_MODE_LEGAL: assert property (mode_legal(pll_mode))
		else $error("reserved multiplier code held");

	AST_SLOW_FROM_LFO: assert property (slow_select && src.lfo_tick |=> clk_out.slow_tick)
		else $error("slow tick missed oscillator tick");

	AST_SYS_DIV_ONE: assert property (
		fast_divisor == 4'h0 && fast_src_tick && $stable(fast_divisor) |=> clk_out.sys_tick)
		else $error("divide by one missed a tick");

	AST_RESERVED_ZERO: assert property (prdata[31:8] == 24'h00_0000)
		else $error("reserved read bits not zero");

endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking testbench for the clock select and prescaler block
`timescale 1ns/100ps
`default_nettype none
module tb;
	import clk_ctrl_pkg::*;
	// ****
	// Stimulus and observed signals
	// ****
	localparam logic [9:0] A_CTRL = {IDX_CLOCK_RESET_CONTROL, 2'b00};
	localparam logic [9:0] A_FAST = {IDX_FAST_CLOCK_PRESCALE, 2'b00};
	localparam logic [9:0] A_SLOW = {IDX_SLOW_CLOCK_PRESCALE, 2'b00};
	localparam logic [9:0] A_AUX = {IDX_AUX_CLOCK_PRESCALE, 2'b00};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h1;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	clk_src_t src = 5'h12; // Main ticking and stable, PLL not stable
	logic power_on_detect = 1'b0;
	clk_out_t clk_out;
	logic pll_shutdown;
	pll_mode_t pll_mode;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	int n_sys, n_slow, n_a1, n_a2;
	logic [31:0] rd;
	logic err;

	always #2 clk = ~clk;

	// PLL ticks every second cycle, LFO every eighth, so sources differ in rate
	always @(posedge clk) begin
		cyc <= cyc + 1;
		src.pll_tick <= (cyc % 2 == 0);
		src.lfo_tick <= (cyc % 8 == 0);
	end

	clock_select_prescaler_ctrl clock_select_prescaler_ctrl_i (.clk(clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
		.power_on_detect(power_on_detect), .clk_out(clk_out), .pll_shutdown(pll_shutdown),
		.pll_mode(pll_mode));

	// ****
	// Shared tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkr(input int got, input int lo, input int hi);
		check_count++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("FAIL %0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask

	// Request held until pready seen high; released on the sampling edge
	task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Values read just after the edge are those sampled at it
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		chkr(n, 1, 19);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [9:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(rd, {24'h00_0000, exp});
	endtask

	// Counts output ticks over 64 cycles, sampled mid-cycle
	task automatic cnt();
		n_sys = 0;
		n_slow = 0;
		n_a1 = 0;
		n_a2 = 0;
		repeat (64) begin
			@(negedge clk);
			n_sys += int'(clk_out.sys_tick === 1'b1);
			n_slow += int'(clk_out.slow_tick === 1'b1);
			n_a1 += int'(clk_out.aux1_tick === 1'b1);
			n_a2 += int'(clk_out.aux2_tick === 1'b1);
		end
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		rdc(A_CTRL, 8'h26);
		rdc(A_FAST, 8'h40);
		rdc(A_SLOW, 8'hB6);
		rdc(A_AUX, 8'hFF);
		apb(1'b0, 10'h104, 8'h00);
		chk({30'h0000_0000, err, |rd}, 32'h0000_0002);
		chk(32'(pll_shutdown), 32'h0000_0001);
		chk(32'(pll_mode), 32'h0000_0004);
	endtask

	// Prescale written only while Main drives the system clock
	task automatic t_mode();
		apb(1'b1, A_FAST, 8'h33);
		rdc(A_FAST, 8'h33);
		chk(32'(pll_mode), 32'h0000_0003);
		apb(1'b1, A_FAST, 8'h75);
		rdc(A_FAST, 8'h35);
		apb(1'b1, A_FAST, 8'h53);
		rdc(A_FAST, 8'h53);
		chk(32'(pll_mode), 32'h0000_0005);
		apb(1'b1, A_FAST, 8'hC3);
		rdc(A_FAST, 8'h43);
		pstrb <= 4'h0;
		apb(1'b1, A_FAST, 8'h00);
		pstrb <= 4'h1;
		rdc(A_FAST, 8'h43);
	endtask

	task automatic t_pll();
		apb(1'b1, A_CTRL, 8'h24);
		rdc(A_CTRL, 8'h26);
		apb(1'b1, A_CTRL, 8'h22);
		rdc(A_CTRL, 8'h22);
		chk(32'(pll_shutdown), 32'h0000_0000);
		apb(1'b1, A_CTRL, 8'h20);
		rdc(A_CTRL, 8'h22);
		src.pll_stable <= 1'b1;
		apb(1'b1, A_CTRL, 8'h20);
		rdc(A_CTRL, 8'h20);
		apb(1'b1, A_CTRL, 8'h24);
		rdc(A_CTRL, 8'h20);
		chk(32'(pll_shutdown), 32'h0000_0000);
	endtask

	task automatic t_clocks();
		apb(1'b1, A_SLOW, 8'h01);
		apb(1'b1, A_AUX, 8'h31);
		repeat (400) @(posedge clk);
		cnt();
		chkr(n_sys, 7, 9);
		chkr(n_a1 + n_a2, 0, 0);
		apb(1'b1, A_CTRL, 8'h3A);
		cnt();
		chkr(n_sys, 15, 17);
		chkr(n_slow, 15, 17);
		chkr(n_a1, 31, 33);
		chkr(n_a2, 15, 17);
		apb(1'b1, A_CTRL, 8'h3B);
		cnt();
		chkr(n_slow, 7, 9);
		@(posedge clk);
		src.main_stable <= 1'b0;
		repeat (4) @(posedge clk);
		cnt();
		chkr(n_a1 + n_a2, 0, 0);
		@(posedge clk);
		src.main_stable <= 1'b1;
	endtask

	task automatic t_por();
		apb(1'b1, A_CTRL, 8'h1B);
		rdc(A_CTRL, 8'h1B);
		apb(1'b1, A_CTRL, 8'h3B);
		rdc(A_CTRL, 8'h1B);
		@(posedge clk);
		power_on_detect <= 1'b1;
		@(posedge clk);
		power_on_detect <= 1'b0;
		rdc(A_CTRL, 8'h3B);
	endtask

	// Watchdog well beyond the expected run of about 800 cycles
	initial begin
		#40000;
		mismatches++;
		give_verdict();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_mode();
		t_pll();
		t_clocks();
		t_por();
		give_verdict();
	end
endmodule
`default_nettype wire
